/* File: core/nv_access_ctrl.sv */
// eeprom byte access controller with storage array
// Functional notes
// (RQ1) mode 01 with armed go erases byte
// (RQ2) mode 10 with armed go writes byte
// (RQ3) go bit reads one until done
// (RQ4) no new operation while busy
// (RQ5) write without erase leaves undefined content
// (RQ6) software erases before split write
// (RQ7) operation time counted on oscillator ticks
// (RQ8) reset does not abort running operation
// (RQ9) nine bit linear byte address
// (RQ10) software loads address before access
// (RQ11) data register supplies and receives byte
// (RQ12) unused high bits read zero
// (RQ13) mode 00 erases and writes together
// (RQ14) arm clears after four cycles
// (RQ15) read fetches byte, halts cpu four
// (RQ16) ready request held while idle
// (RQ17) mode 11 starts nothing
`timescale 1ns/1ps
module nv_access_ctrl
  import nv_access_pkg::*;
#(
  parameter int ATOMIC_T = ATOMIC_TICKS,
  parameter int SPLIT_T = SPLIT_TICKS
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // oscillator
  input wire logic i_osc_clk,
  // register port
  input wire logic [1:0] i_reg_sel,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // cpu side
  output logic o_cpu_halt,
  output logic o_ready_irq
);
  typedef enum logic [1:0] {ST_IDLE, ST_BUSY} op_state_type;
  op_state_type state_r;
  logic [ADDR_W-1:0] nv_byte_address_r;
  logic [7:0] nv_data_byte_r;
  logic [1:0] program_mode_field_r;
  logic ready_irq_enable_r;
  logic [2:0] arm_cnt_r;
  logic [1:0] op_mode_r;
  logic [ADDR_W-1:0] op_addr_r;
  logic [7:0] op_data_r;
  logic [23:0] tick_cnt_r;
  logic [2:0] halt_cnt_r;
  logic [7:0] mem [0:(1<<ADDR_W)-1];
  logic tick;
  logic busy;
  logic ctl_wr;
  logic go_req;
  logic read_req;
  logic [23:0] op_len;

  function automatic logic [23:0] mode_len(input logic [1:0] m);
    mode_len = (m == PM_ATOMIC) ? 24'(ATOMIC_T) : 24'(SPLIT_T);
  endfunction : mode_len

  nv_tick_sync u_sync (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_osc_clk(i_osc_clk),
    .o_tick(tick)
  );

  assign busy = (state_r == ST_BUSY);
  assign ctl_wr = i_reg_wr && (i_reg_sel == SEL_CONTROL);
  // ==========================================
  // request decode
  assign go_req = ctl_wr && i_reg_wdata[BIT_GO] && (arm_cnt_r != 3'h0) && !busy
    && (program_mode_field_r != PM_RESERVED); // see (RQ1) (RQ2) (RQ4) (RQ13) (RQ14) (RQ17)
  assign read_req = ctl_wr && i_reg_wdata[BIT_READ] && !busy; // see (RQ4) (RQ15)
  assign op_len = mode_len(op_mode_r);

  // ==========================================
  // operation engine, not reset so a running write completes
  always_ff @(posedge i_mclk) begin
    if (go_req) begin
      state_r <= ST_BUSY; // see (RQ3)
      op_mode_r <= program_mode_field_r;
      op_addr_r <= nv_byte_address_r;
      op_data_r <= nv_data_byte_r;
      tick_cnt_r <= 24'h000000;
    end else if (busy) begin
      if (tick) begin
        tick_cnt_r <= tick_cnt_r + 24'h000001; // see (RQ7)
      end
      if (tick_cnt_r >= op_len) begin
        state_r <= ST_IDLE; // see (RQ8)
        unique case (op_mode_r)
          PM_ATOMIC: mem[op_addr_r] <= op_data_r; // see (RQ13)
          PM_ERASE: mem[op_addr_r] <= ERASED_BYTE; // see (RQ1)
          PM_WRITE: mem[op_addr_r] <= mem[op_addr_r] & op_data_r; // see (RQ2) (RQ5)
          default: ;
        endcase
      end
    end else begin
      // idle or unknown code settles to idle without aborting a busy state
      unique case (state_r)
        ST_BUSY: ;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ==========================================
  // address register, frozen while busy
  always_ff @(posedge i_mclk) begin
    if (i_reg_wr && !busy && i_reg_sel == SEL_ADDR_LOW) begin
      nv_byte_address_r[7:0] <= i_reg_wdata; // see (RQ9)
    end
    if (i_reg_wr && !busy && i_reg_sel == SEL_ADDR_HIGH) begin
      nv_byte_address_r[8] <= i_reg_wdata[0]; // see (RQ9)
    end
  end

  // ==========================================
  // data register
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      nv_data_byte_r <= DATA_RST;
    end else if (read_req) begin
      nv_data_byte_r <= mem[nv_byte_address_r]; // see (RQ11) (RQ15)
    end else if (i_reg_wr && i_reg_sel == SEL_DATA) begin
      nv_data_byte_r <= i_reg_wdata; // see (RQ11)
    end
  end

  // ==========================================
  // control fields; mode kept over reset while busy
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst && !busy) begin
      program_mode_field_r <= PM_ATOMIC;
    end else if (ctl_wr && !busy) begin
      program_mode_field_r <= i_reg_wdata[BIT_PM_HI:BIT_PM_LO];
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ready_irq_enable_r <= 1'b0;
      arm_cnt_r <= 3'h0;
    end else begin
      if (ctl_wr) begin
        ready_irq_enable_r <= i_reg_wdata[BIT_RIE];
      end
      if (ctl_wr && i_reg_wdata[BIT_ARM]) begin
        arm_cnt_r <= 3'(ARM_CYCLES); // see (RQ14)
      end else if (arm_cnt_r != 3'h0) begin
        arm_cnt_r <= arm_cnt_r - 3'h1; // see (RQ14)
      end
    end
  end

  // ==========================================
  // cpu halt, ready request, read-back
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      halt_cnt_r <= 3'h0;
      o_cpu_halt <= 1'b0;
      o_ready_irq <= 1'b0;
      o_reg_rdata <= 8'h00;
    end else begin
      if (read_req) begin
        halt_cnt_r <= 3'(READ_HALT_CYCLES); // see (RQ15)
      end else if (go_req) begin
        halt_cnt_r <= 3'(WRITE_HALT_CYCLES);
      end else if (halt_cnt_r != 3'h0) begin
        halt_cnt_r <= halt_cnt_r - 3'h1;
      end
      o_cpu_halt <= read_req || go_req || (halt_cnt_r > 3'h1);
      o_ready_irq <= ready_irq_enable_r && !busy && !go_req; // see (RQ16)
      unique case (i_reg_sel)
        SEL_ADDR_LOW: o_reg_rdata <= nv_byte_address_r[7:0];
        SEL_ADDR_HIGH: o_reg_rdata <= {7'h00, nv_byte_address_r[8]}; // see (RQ12)
        SEL_DATA: o_reg_rdata <= nv_data_byte_r;
        SEL_CONTROL: o_reg_rdata <= {2'h0, program_mode_field_r, ready_irq_enable_r,
          (arm_cnt_r != 3'h0), busy, 1'b0}; // see (RQ3) (RQ12)
      endcase
    end
  end
endmodule : nv_access_ctrl

/* File: core/nv_access_pkg.sv */
// constants for the eeprom access controller
package nv_access_pkg;
  // ==========================================
  // register selection (no bus: a small local register select)
  localparam logic [1:0] SEL_ADDR_LOW = 2'h0;
  localparam logic [1:0] SEL_ADDR_HIGH = 2'h1;
  localparam logic [1:0] SEL_DATA = 2'h2;
  localparam logic [1:0] SEL_CONTROL = 2'h3;
  // ==========================================
  // control register fields
  localparam int BIT_READ = 0;
  localparam int BIT_GO = 1;
  localparam int BIT_ARM = 2;
  localparam int BIT_RIE = 3;
  localparam int BIT_PM_LO = 4;
  localparam int BIT_PM_HI = 5;
  localparam int ADDR_W = 9;
  localparam logic [1:0] PM_ATOMIC = 2'h0;
  localparam logic [1:0] PM_ERASE = 2'h1;
  localparam logic [1:0] PM_WRITE = 2'h2;
  localparam logic [1:0] PM_RESERVED = 2'h3;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // ==========================================
  // timing
  localparam int ARM_CYCLES = 4;
  localparam int READ_HALT_CYCLES = 4;
  localparam int WRITE_HALT_CYCLES = 2;
  localparam real OSC_MHZ = 8.0;
  localparam real T_ATOMIC_US = 3400.0;
  localparam real T_SPLIT_US = 1800.0;
  localparam int ATOMIC_TICKS = int'(T_ATOMIC_US * OSC_MHZ);
  localparam int SPLIT_TICKS = int'(T_SPLIT_US * OSC_MHZ);
endpackage : nv_access_pkg

/* File: core/nv_tick_sync.sv */
// synchroniser and edge detector for the oscillator tick
`timescale 1ns/1ps
module nv_tick_sync (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // oscillator
  input wire logic i_osc_clk,
  // output
  output logic o_tick
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  // ==========================================
  // two flops then rising edge
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      o_tick <= 1'b0;
    end else begin
      s1_r <= i_osc_clk;
      s2_r <= s1_r;
      s3_r <= s2_r;
      o_tick <= s2_r & ~s3_r;
    end
  end
endmodule : nv_tick_sync

/* File: sim/nv_osc_model.sv */
// free-running model of the calibrated timing oscillator
`timescale 1ns/1ps
module nv_osc_model #(parameter real HALF_NS = 62.5) (
  // oscillator
  output logic o_osc_clk
);
  initial begin
    o_osc_clk = 1'b0;
    forever #(HALF_NS) o_osc_clk = ~o_osc_clk;
  end
endmodule : nv_osc_model

/* File: sim/nv_access_props.sv */
// checker for the eeprom access controller
`timescale 1ns/1ps
module nv_access_props
  import nv_access_pkg::*;
#(parameter int ATOMIC_T = 5, parameter int SPLIT_T = 3) (
  // inputs
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_osc_clk,
  input wire logic [1:0] i_reg_sel,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  // outputs
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_cpu_halt,
  input wire logic o_ready_irq
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  // ==========================================
  // properties
  a_halt_min: assert property ($rose(o_cpu_halt) |-> o_cpu_halt[*2]) else $error("halt too short");
  a_halt_max: assert property (o_cpu_halt[*4] |=> !o_cpu_halt) else $error("halt too long");
  a_halt_cause: assert property ($rose(o_cpu_halt) |-> $past(i_reg_wr && i_reg_sel == SEL_CONTROL))
    else $error("halt without control write");
  a_ctrl_zero: assert property ($past(i_reg_sel) == SEL_CONTROL |-> o_reg_rdata[7:6] == 2'h0)
    else $error("control top bits set");
  a_high_zero: assert property ($past(i_reg_sel) == SEL_ADDR_HIGH |-> o_reg_rdata[7:1] == 7'h0)
    else $error("address high top bits set");
  a_busy_irq: assert property ($past(i_reg_sel) == SEL_CONTROL && o_reg_rdata[1] |-> !o_ready_irq)
    else $error("ready request while busy");
  a_irq_off: assert property (i_reg_wr && i_reg_sel == SEL_CONTROL && !i_reg_wdata[BIT_RIE] |=> ##1 !o_ready_irq)
    else $error("ready request while disabled");
  a_data_back: assert property (i_reg_wr && i_reg_sel == SEL_DATA ##1 i_reg_sel == SEL_DATA
    |=> o_reg_rdata == $past(i_reg_wdata, 2)) else $error("data readback wrong");
endmodule : nv_access_props
bind nv_access_ctrl nv_access_props #(.ATOMIC_T(ATOMIC_T), .SPLIT_T(SPLIT_T)) u_props (.i_mclk(i_mclk),
  .i_sys_rst(i_sys_rst), .i_osc_clk(i_osc_clk), .i_reg_sel(i_reg_sel), .i_reg_wr(i_reg_wr),
  .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_cpu_halt(o_cpu_halt), .o_ready_irq(o_ready_irq));

/* File: sim/eeprom_access_controller_tb.sv */
// bench for the eeprom access controller
`timescale 1ns/1ps
module eeprom_access_controller_tb;
  import nv_access_pkg::*;
  logic i_mclk, i_sys_rst, i_osc_clk, i_reg_wr, o_cpu_halt, o_ready_irq, rd_v, rd_d;
  logic [1:0] i_reg_sel;
  logic [7:0] i_reg_wdata, o_reg_rdata, d;
  logic [8:0] a;
  logic [15:0] m, q[$];
  int err_total = 0, checks = 0;
  nv_access_ctrl #(.ATOMIC_T(5), .SPLIT_T(3)) dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_osc_clk(i_osc_clk),
    .i_reg_sel(i_reg_sel), .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .o_cpu_halt(o_cpu_halt), .o_ready_irq(o_ready_irq));
  nv_osc_model osc (.o_osc_clk(i_osc_clk));
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  // ==========================================
  // checking
  task automatic chk(input string n, input logic [7:0] e, g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  always @(posedge i_mclk) begin
    if (rd_d === 1'b1) begin
      m = q.pop_front();
      chk("rdata", m[7:0], o_reg_rdata & m[15:8]);
    end
    rd_d <= rd_v;
  end
  task automatic conclude();
    if (err_total == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude
  // ==========================================
  // register access
  task automatic wr(input logic [1:0] s, input logic [7:0] v);
    @(posedge i_mclk);
    i_reg_sel <= s;
    i_reg_wdata <= v;
    i_reg_wr <= 1'b1;
    @(posedge i_mclk);
    i_reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] s, input logic [7:0] k, e);
    @(posedge i_mclk);
    i_reg_sel <= s;
    rd_v <= 1'b1;
    q.push_back({k, e & k});
    @(posedge i_mclk);
    rd_v <= 1'b0;
  endtask : rd
  task automatic idle();
    repeat (100) begin
      @(posedge i_mclk);
      i_reg_sel <= SEL_CONTROL;
      repeat (2) @(posedge i_mclk);
      if (o_reg_rdata[1] === 1'b0) return;
    end
    err_total++;
    $display("Error busy expected 0 seen %b", o_reg_rdata[1]);
  endtask : idle
  task automatic op(input logic [1:0] md, input logic [7:0] v, e);
    wr(SEL_DATA, v);
    wr(SEL_CONTROL, {2'h0, md, 4'h4});
    wr(SEL_CONTROL, {2'h0, md, 4'h6});
    rd(SEL_CONTROL, 8'h02, (md == PM_RESERVED) ? 8'h00 : 8'h02);
    idle();
    wr(SEL_CONTROL, {2'h0, md, 4'h1});
    repeat (4) @(posedge i_mclk);
    rd(SEL_DATA, 8'hff, e);
  endtask : op
  // ==========================================
  // scenarios
  initial begin
    void'($urandom(32'h4ace));
    i_sys_rst = 1'b1;
    i_reg_wr = 1'b0;
    i_reg_sel = SEL_DATA;
    i_reg_wdata = 8'h00;
    rd_v = 1'b0;
    rd_d = 1'b0;
    d = 8'($urandom);
    a = 9'($urandom);
    repeat (8) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    rd(SEL_DATA, 8'hff, DATA_RST);
    wr(SEL_ADDR_LOW, a[7:0]);
    wr(SEL_ADDR_HIGH, {7'h7f, a[8]});
    rd(SEL_ADDR_HIGH, 8'hff, {7'h0, a[8]});
    wr(SEL_CONTROL, 8'hc2);
    rd(SEL_CONTROL, 8'hc2, 8'h00);
    op(PM_ATOMIC, d, d);
    op(PM_ERASE, ~d, ERASED_BYTE);
    op(PM_WRITE, d ^ 8'h5a, d ^ 8'h5a);
    op(PM_RESERVED, 8'h00, d ^ 8'h5a);
    wr(SEL_DATA, ~d);
    wr(SEL_CONTROL, 8'h04);
    wr(SEL_CONTROL, 8'h06);
    wr(SEL_ADDR_LOW, ~a[7:0]);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    idle();
    rd(SEL_ADDR_LOW, 8'hff, a[7:0]);
    wr(SEL_CONTROL, 8'h01);
    repeat (4) @(posedge i_mclk);
    rd(SEL_DATA, 8'hff, ~d);
    wr(SEL_CONTROL, 8'h08);
    repeat (2) @(posedge i_mclk);
    chk("irq", 8'h01, {7'h0, o_ready_irq});
    wr(SEL_CONTROL, 8'h0c);
    wr(SEL_CONTROL, 8'h0e);
    repeat (2) @(posedge i_mclk);
    chk("irq", 8'h00, {7'h0, o_ready_irq});
    idle();
    conclude();
  end
  initial begin
    #200us;
    err_total++;
    conclude();
  end
endmodule : eeprom_access_controller_tb
